// File: logic/wdw_top.sv
/*
  windowed watchdog with avalon-mm register slave and interrupt.
  assumes cfg_word is static after reset, clk_switch_done and wake_in are
  one-cycle pulses from the clock and interrupt logic, and device_reset_req
  is fed back into the system reset tree.
*/
`timescale 1ns/1ps
module wdw_top #(
  parameter int RC_DIV = wdw_pkg::RC_DIV_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire wdw_pkg::wdw_cfg_t cfg_word,
  input wire logic clk_switch_done,
  input wire logic wake_in,
  output logic osc_en,
  output logic device_reset_req,
  output logic wake_out,
  output logic irq
);
  import wdw_pkg::*;

  // bus slave: one wait cycle, then answer
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wr_go, rd_go, be0;

  // watchdog state
  wdw_mode_t mode_r, mode_nxt;
  wdw_rstctl_t rc_r, rc_nxt;
  logic [EV_N-1:0] sts_r, sts_nxt, mask_r, mask_nxt;
  logic [15:0] div_r, div_nxt;
  logic tick_r, tick_nxt;
  logic rst_r, rst_nxt, wake_r, wake_nxt;

  logic run, kick, ps_enter, ps_exit, early, scl_clr, timeout, in_window;
  logic [CNT_W-1:0] elapsed;
  logic [EV_N-1:0] ev;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_go = avs_write & ack_r;
  assign rd_go = avs_read & ~ack_r;
  assign be0 = avs_byteenable[0];
  assign avs_readdata = rdata_r;

  assign run = cfg_word.hard_enable_cfg_bit | rc_r.soft_enable_bit;
  assign osc_en = run;
  assign kick = wr_go & be0 & (avs_address == ADR_KICK) & avs_writedata[0];
  assign ps_enter = wr_go & be0 & (avs_address == ADR_PSAVE) & (avs_writedata[1:0] != 2'h0)
                    & (mode_r == WDW_RUN);
  assign ps_exit = (mode_r != WDW_RUN) & (wake_in | (timeout & run));
  // kick ahead of the final quarter only matters while running in window mode
  assign early = kick & run & ~cfg_word.window_disable_bit & ~in_window;
  // mode is left out on purpose so the count carries on in sleep and idle
  assign scl_clr = kick | ps_enter | ps_exit | clk_switch_done | rst_r | ~run;

  wdw_scaler wdw_scaler_inst (
    .core_clk(core_clk),
    .nrst(nrst),
    .tick(tick_r),
    .clr(scl_clr),
    .pre_sel(cfg_word.prescale_select_bit),
    .post_sel(cfg_word.postscale_select_field),
    .timeout(timeout),
    .in_window(in_window),
    .elapsed(elapsed)
  );

  // slow oscillator model: ticks only while enabled
  always_comb begin
    div_nxt = div_r;
    tick_nxt = 1'b0;
    if (!run) begin
      div_nxt = '0;
    end else if (div_r >= 16'(RC_DIV - 1)) begin
      div_nxt = '0;
      tick_nxt = 1'b1;
    end else begin
      div_nxt = div_r + 16'h1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_r <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign ev[EV_TIMEOUT] = timeout & run;
  assign ev[EV_WAKE] = ps_exit;
  assign ev[EV_EARLY] = early;

  always_comb begin
    mode_nxt = mode_r;
    rc_nxt = rc_r;
    sts_nxt = sts_r;
    mask_nxt = mask_r;
    rst_nxt = 1'b0;
    wake_nxt = 1'b0;
    if (wr_go && be0) begin
      case (avs_address)
        ADR_RSTCTL: begin
          rc_nxt.soft_enable_bit = avs_writedata[BIT_SOFT_EN];
          // status bits clear by writing one
          if (avs_writedata[BIT_FLAG]) rc_nxt.timeout_flag = 1'b0;
          if (avs_writedata[BIT_SLEEP]) rc_nxt.sleep_bit = 1'b0;
          if (avs_writedata[BIT_IDLE]) rc_nxt.idle_bit = 1'b0;
        end
        ADR_STATUS: sts_nxt = sts_r & ~avs_writedata[EV_N-1:0];
        ADR_MASK: mask_nxt = avs_writedata[EV_N-1:0];
        default: ;
      endcase
    end
    if (ps_enter) begin
      mode_nxt = avs_writedata[0] ? WDW_SLEEP : WDW_IDLE;
      if (avs_writedata[0]) rc_nxt.sleep_bit = 1'b1;
      else rc_nxt.idle_bit = 1'b1;
    end
    if (ps_exit) begin
      mode_nxt = WDW_RUN;
      wake_nxt = 1'b1;
    end else if ((timeout && run && mode_r == WDW_RUN) || early) begin
      rst_nxt = 1'b1;
    end
    // sets win over a same-cycle software clear
    if (timeout && run) rc_nxt.timeout_flag = 1'b1;
    if (early) rc_nxt.timeout_flag = 1'b1;
    sts_nxt = sts_nxt | ev;
    if (rst_r) begin
      rc_nxt.soft_enable_bit = 1'b0;
      mode_nxt = WDW_RUN;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= WDW_RUN;
      rc_r <= '0;
      sts_r <= '0;
      mask_r <= MASK_RST;
      rst_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      rc_r <= rc_nxt;
      sts_r <= sts_nxt;
      mask_r <= mask_nxt;
      rst_r <= rst_nxt;
      wake_r <= wake_nxt;
    end
  end

  assign device_reset_req = rst_r;
  assign wake_out = wake_r;
  assign irq = |(sts_r & mask_r);

  always_comb begin
    ack_nxt = (avs_read | avs_write) & ~ack_r;
    rdata_nxt = rdata_r;
    if (rd_go) begin
      rdata_nxt = '0;
      case (avs_address)
        ADR_RSTCTL: rdata_nxt[BIT_SOFT_EN:BIT_IDLE] = rc_r;
        ADR_STATUS: rdata_nxt[EV_N-1:0] = sts_r;
        ADR_MASK: rdata_nxt[EV_N-1:0] = mask_r;
        ADR_CFG: rdata_nxt[7:0] = cfg_word;
        ADR_COUNT: rdata_nxt[CNT_W-1:0] = elapsed;
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ack_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // a tick only follows a cycle in which the oscillator ran
  osc_follows_en_a: assert property (tick_r |-> $past(osc_en))
    else $error("oscillator tick without watchdog enable");

  hard_keeps_run_a: assert property (cfg_word.hard_enable_cfg_bit |-> ##1 osc_en)
    else $error("hard enable did not keep watchdog running");

  soft_clr_ignored_a: assert property ((cfg_word.hard_enable_cfg_bit && wr_go && be0
      && avs_address == ADR_RSTCTL && !avs_writedata[BIT_SOFT_EN]) |=> osc_en)
    else $error("soft clear stopped a hard-enabled watchdog");

  soft_gate_a: assert property ((!cfg_word.hard_enable_cfg_bit && !rc_r.soft_enable_bit)
      |=> elapsed == '0)
    else $error("watchdog counted without any enable");

  reset_clears_soft_a: assert property (device_reset_req |=> !rc_r.soft_enable_bit)
    else $error("device reset left soft enable set");

  reset_clears_cnt_a: assert property (device_reset_req |=> elapsed == '0)
    else $error("device reset did not clear the count");

  kick_clears_cnt_a: assert property (kick |=> elapsed == '0)
    else $error("kick did not clear the count");

  switch_clears_a: assert property (clk_switch_done |=> elapsed == '0)
    else $error("clock switch did not clear the count");

  psave_clears_cnt_a: assert property ((ps_enter || ps_exit) |=> elapsed == '0)
    else $error("power-save transition did not clear the count");

  wake_in_exit_a: assert property ((mode_r != WDW_RUN && wake_in)
      |=> mode_r == WDW_RUN && wake_out && elapsed == '0)
    else $error("wake input did not end power save");

  // one step at a time; a repetition over a whole period would be far too long
  sleep_counts_a: assert property ((mode_r != WDW_RUN && run && tick_r && !scl_clr)
      |=> timeout || elapsed == $past(elapsed) + CNT_W'(1))
    else $error("count stopped during sleep or idle");

  sleep_enter_a: assert property ((ps_enter && avs_writedata[0] && !device_reset_req)
      |=> mode_r == WDW_SLEEP && rc_r.sleep_bit)
    else $error("sleep entry not recorded");

  idle_enter_a: assert property ((ps_enter && !avs_writedata[0] && !device_reset_req)
      |=> mode_r == WDW_IDLE && rc_r.idle_bit)
    else $error("idle entry not recorded");

  sleep_wakes_a: assert property ((mode_r != WDW_RUN && timeout && run)
      |=> wake_out && !device_reset_req && mode_r == WDW_RUN)
    else $error("timeout in power save did not wake");

  wake_no_reset_a: assert property (wake_out |-> !device_reset_req)
    else $error("wake and reset raised together");

  run_resets_a: assert property ((mode_r == WDW_RUN && timeout && run)
      |=> device_reset_req && rc_r.timeout_flag)
    else $error("timeout in run did not reset and flag");

  flag_on_reset_a: assert property (device_reset_req |-> rc_r.timeout_flag)
    else $error("watchdog reset without timeout flag");

  timeout_status_a: assert property ((timeout && run)
      |=> sts_r[EV_TIMEOUT] && rc_r.timeout_flag)
    else $error("timeout not recorded");

  // set wins over a same-cycle clear, so only a real clear may drop a flag
  flag_sticky_a: assert property ((rc_r.timeout_flag && !(wr_go && be0
      && avs_address == ADR_RSTCTL && avs_writedata[BIT_FLAG])) |=> rc_r.timeout_flag)
    else $error("timeout flag cleared without software");

  status_sticky_a: assert property ((sts_r[EV_WAKE] && !(wr_go && be0 && avs_address == ADR_STATUS
      && avs_writedata[EV_WAKE])) |=> sts_r[EV_WAKE])
    else $error("wake status cleared without software");

  early_kick_a: assert property ((kick && run && !cfg_word.window_disable_bit && !in_window)
      |=> device_reset_req)
    else $error("early kick in window mode did not reset");

  early_status_a: assert property (early |=> sts_r[EV_EARLY] && rc_r.timeout_flag)
    else $error("early kick not recorded");

  // kicks while asleep are not expected; the window checks only watch run mode
  win_kick_safe_a: assert property ((kick && in_window && mode_r == WDW_RUN && !timeout)
      |=> !device_reset_req)
    else $error("kick inside the window reset the device");

  nowin_kick_a: assert property ((kick && cfg_word.window_disable_bit && mode_r == WDW_RUN
      && !timeout) |=> !device_reset_req)
    else $error("kick reset the device in non-window mode");

  pre_period_a: assert property ((cfg_word.postscale_select_field == 4'h0)
      |-> elapsed < (cfg_word.prescale_select_bit ? CNT_W'(PRE_LONG_DIV) : CNT_W'(PRE_SHORT_DIV)))
    else $error("count passed the prescaler period");

  pre_figures_a: assert property ((cfg_word.postscale_select_field == 4'h0 && tick_r && !scl_clr
      && elapsed == (cfg_word.prescale_select_bit ? CNT_W'(PRE_LONG_DIV - 1) : CNT_W'(PRE_SHORT_DIV - 1)))
      |=> timeout)
    else $error("prescaler period did not end in a timeout");

  post_ratio_a: assert property (elapsed < wdw_term(cfg_word.prescale_select_bit,
      cfg_word.postscale_select_field))
    else $error("count passed the selected period");

  post_timeout_a: assert property ((tick_r && !scl_clr
      && elapsed == wdw_term(cfg_word.prescale_select_bit, cfg_word.postscale_select_field) - CNT_W'(1))
      |=> timeout)
    else $error("selected period did not end in a timeout");

endmodule

// File: logic/wdw_pkg.sv
/*
  constants, types and helpers shared by the windowed watchdog.
  assumes a 50 mhz core_clk and a configuration word held steady by the
  non-volatile fuse logic outside.

// Overview of operation
// - counting runs on the slow rc oscillator; enabling the watchdog enables it
// - prescaler divides the oscillator by 32 or 128 per prescale_select_bit
// - prescaler alone gives 1 ms in 32-mode, 4 ms in 128-mode
// - postscaler divides further by one of 16 ratios, 1:1 to 1:32768
// - counters clear on reset, clock switch, power-save entry and exit, kick
// - an enabled watchdog keeps counting in sleep and idle
// - timeout in sleep or idle wakes the device instead of resetting it
// - timeout_flag is sticky; only software clears it
// - hard_enable_cfg_bit set keeps the watchdog always running
// - with hard_enable_cfg_bit clear, soft_enable_bit alone enables it
// - every device reset clears soft_enable_bit
// - in window mode a kick before the window causes a watchdog reset
// - prescale_select_bit 1 means divide by 128, 0 divide by 32
// - window_disable_bit 1 is non-window mode, 0 window mode
// - with hard enable set, clearing soft_enable_bit does nothing
*/
package wdw_pkg;

  localparam int CLK_FREQ_HZ = 50000000;
  localparam int RC_FREQ_HZ = 32000;
  // core cycles per slow oscillator period, rounded down
  localparam int RC_DIV_CYC = CLK_FREQ_HZ / RC_FREQ_HZ;
  localparam int PRE_SHORT_US = 1000;
  localparam int PRE_LONG_US = 4000;
  localparam int PRE_SHORT_DIV = PRE_SHORT_US * RC_FREQ_HZ / 1000000;
  localparam int PRE_LONG_DIV = PRE_LONG_US * RC_FREQ_HZ / 1000000;
  // one bit above the longest period, 128 << 15 ticks
  localparam int CNT_W = 23;

  localparam logic [4:0] ADR_RSTCTL = 5'h00;
  localparam logic [4:0] ADR_KICK = 5'h04;
  localparam logic [4:0] ADR_PSAVE = 5'h08;
  localparam logic [4:0] ADR_STATUS = 5'h0c;
  localparam logic [4:0] ADR_MASK = 5'h10;
  localparam logic [4:0] ADR_CFG = 5'h14;
  localparam logic [4:0] ADR_COUNT = 5'h18;

  localparam int BIT_IDLE = 2;
  localparam int BIT_SLEEP = 3;
  localparam int BIT_FLAG = 4;
  localparam int BIT_SOFT_EN = 5;
  localparam int EV_TIMEOUT = 0;
  localparam int EV_WAKE = 1;
  localparam int EV_EARLY = 2;
  localparam int EV_N = 3;
  localparam logic [EV_N-1:0] MASK_RST = 3'h0;

  typedef struct packed {
    logic hard_enable_cfg_bit;
    logic window_disable_bit;
    logic unused_bit;
    logic prescale_select_bit;
    logic [3:0] postscale_select_field;
  } wdw_cfg_t;

  typedef struct packed {
    logic soft_enable_bit;
    logic timeout_flag;
    logic sleep_bit;
    logic idle_bit;
  } wdw_rstctl_t;

  typedef enum logic [1:0] {WDW_RUN, WDW_SLEEP, WDW_IDLE} wdw_mode_t;

  // full period in oscillator ticks
  function automatic logic [CNT_W-1:0] wdw_term(input logic pre_sel, input logic [3:0] post);
    logic [CNT_W-1:0] base;
    base = pre_sel ? CNT_W'(PRE_LONG_DIV) : CNT_W'(PRE_SHORT_DIV);
    return base << post;
  endfunction

endpackage

// File: logic/wdw_scaler.sv
/*
  combined prescaler and postscaler of the watchdog as one tick counter.
  assumes tick is a one-cycle pulse per slow oscillator period.
*/
`timescale 1ns/1ps
module wdw_scaler (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic clr,
  input wire logic pre_sel,
  input wire logic [3:0] post_sel,
  output logic timeout,
  output logic in_window,
  output logic [wdw_pkg::CNT_W-1:0] elapsed
);
  import wdw_pkg::*;

  logic [CNT_W-1:0] cnt_r, cnt_nxt, term;
  logic to_r, to_nxt;

  always_comb begin
    term = wdw_term(pre_sel, post_sel);
    cnt_nxt = cnt_r;
    to_nxt = 1'b0;
    if (clr) begin
      cnt_nxt = '0;
    end else if (tick) begin
      if (cnt_r + CNT_W'(1) >= term) begin
        cnt_nxt = '0;
        to_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
      to_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      to_r <= to_nxt;
    end
  end

  // final quarter of the period
  assign in_window = cnt_r >= (term - (term >> 2));
  assign timeout = to_r;
  assign elapsed = cnt_r;
endmodule

// File: sim/wdw_top_bench.sv
/*
  self-checking bench for the windowed watchdog top level.
  assumes RC_DIV may be shrunk to 2 and the bench drives cfg_word like the fuse logic.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module wdw_top_bench;
  import wdw_pkg::*;
  localparam int RCD = 2;
  logic core_clk, nrst, avs_read, avs_write, avs_waitrequest, clk_switch_done, wake_in;
  logic osc_en, device_reset_req, wake_out, irq;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] be;
  wdw_cfg_t cfg_word;
  int mismatches, samples_checked, rst_cnt, wake_cnt, t, s, x;
  wdw_top #(.RC_DIV(RCD)) wdw_top_inst (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cfg_word(cfg_word),
    .clk_switch_done(clk_switch_done), .wake_in(wake_in), .osc_en(osc_en),
    .device_reset_req(device_reset_req), .wake_out(wake_out), .irq(irq));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // pulses counted at the edge, read by the tasks mid-cycle, so no race on the count
  always @(posedge core_clk) begin
    if (device_reset_req === 1'b1) rst_cnt <= rst_cnt + 1;
    if (wake_out === 1'b1) wake_cnt <= wake_cnt + 1;
  end
  task automatic finish_test;
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      finish_test();
    end
  endtask
  task automatic do_reset(input wdw_cfg_t c);
    @(posedge core_clk);
    nrst <= 1'b0;
    cfg_word <= c;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
  endtask
  // bounded wait for a reset (wk=0) or wake (wk=1) pulse
  task automatic wait_evt(input bit wk, input int lim, output int c);
    int s0;
    s0 = wk ? wake_cnt : rst_cnt;
    c = 0;
    while ((wk ? wake_cnt : rst_cnt) == s0 && c < lim) begin
      @(negedge core_clk);
      c++;
    end
    if (c >= lim) begin
      mismatches++;
      finish_test();
    end
  endtask
  task automatic t_reset;
    do_reset(8'h40);
    bus(0, ADR_RSTCTL, 0);
    `CHK(rd, 32'h0)
    @(negedge core_clk);
    `CHK(osc_en, 1'b0)
    bus(0, 5'h1c, 0);
    `CHK(rd, 32'h0)
    bus(0, ADR_CFG, 0);
    `CHK(rd, 32'h40)
    be <= 4'h0;
    bus(1, ADR_MASK, 32'h7);
    be <= 4'hf;
    bus(0, ADR_MASK, 0);
    `CHK(rd, 32'h0)
    s = rst_cnt;
    repeat (300) @(negedge core_clk);
    `CHK(rst_cnt, s)
  endtask
  task automatic t_soft;
    bus(1, ADR_RSTCTL, 32'h20);
    @(negedge core_clk);
    `CHK(osc_en, 1'b1)
    wait_evt(0, 200, t);
    `CHK((t >= 31 * RCD && t <= 33 * RCD + 4), 1'b1)
    bus(0, ADR_RSTCTL, 0);
    `CHK(rd, 32'h10)
    repeat (100) @(posedge core_clk);
    bus(0, ADR_RSTCTL, 0);
    `CHK(rd, 32'h10)
    bus(1, ADR_RSTCTL, 32'h10);
    bus(0, ADR_RSTCTL, 0);
    `CHK(rd, 32'h0)
  endtask
  // both prescale picks at postscale 1:1, plus 32 at 1:8 and 128 at 1:4, measured from reset release
  task automatic t_periods;
    logic [4:0] sel [4] = '{5'h00, 5'h10, 5'h03, 5'h12};
    for (int i = 0; i < 4; i++) begin
      x = (sel[i][4] ? 128 : 32) << sel[i][3:0];
      do_reset({3'b110, sel[i]});
      wait_evt(0, x * RCD + 50, t);
      `CHK((t >= (x - 1) * RCD && t <= (x + 1) * RCD + 4), 1'b1)
    end
  endtask
  task automatic t_kick;
    do_reset(8'hc0);
    s = rst_cnt;
    repeat (5) begin
      repeat (40) @(posedge core_clk);
      bus(1, ADR_KICK, 32'h1);
    end
    repeat (4) begin
      repeat (40) @(posedge core_clk);
      clk_switch_done <= 1'b1;
      @(posedge core_clk);
      clk_switch_done <= 1'b0;
    end
    `CHK(rst_cnt, s)
    bus(1, ADR_RSTCTL, 32'h0);
    @(negedge core_clk);
    `CHK(osc_en, 1'b1)
    wait_evt(0, 100, t);
  endtask
  task automatic t_window;
    do_reset(8'h80);
    bus(1, ADR_KICK, 32'h1);
    wait_evt(0, 6, t);
    bus(0, ADR_STATUS, 0);
    `CHK(rd[2], 1'b1)
    x = 0;
    rd = 0;
    while (rd < 26 && x < 40) begin
      bus(0, ADR_COUNT, 0);
      x++;
    end
    if (x >= 40) begin
      mismatches++;
      finish_test();
    end
    s = rst_cnt;
    bus(1, ADR_KICK, 32'h1);
    repeat (30) @(negedge core_clk);
    `CHK(rst_cnt, s)
  endtask
  task automatic t_sleep;
    do_reset(8'hc0);
    bus(1, ADR_MASK, 32'h2);
    bus(1, ADR_PSAVE, 32'h1);
    bus(0, ADR_RSTCTL, 0);
    `CHK(rd, 32'h08)
    s = rst_cnt;
    wait_evt(1, 100, t);
    `CHK(rst_cnt, s)
    bus(0, ADR_RSTCTL, 0);
    `CHK(rd, 32'h18)
    `CHK(irq, 1'b1)
    bus(1, ADR_RSTCTL, 32'h18);
    bus(1, ADR_STATUS, 32'h7);
    @(negedge core_clk);
    `CHK(irq, 1'b0)
    bus(1, ADR_PSAVE, 32'h2);
    bus(0, ADR_RSTCTL, 0);
    `CHK(rd, 32'h04)
    // exit from idle restarts the count, so the next event is a full run period
    wake_in <= 1'b1;
    @(posedge core_clk);
    wake_in <= 1'b0;
    wait_evt(0, 100, t);
    `CHK((t >= 31 * RCD), 1'b1)
  endtask
  initial begin
    nrst = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    be = 4'hf;
    cfg_word = 8'h40;
    clk_switch_done = 1'b0;
    wake_in = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    rst_cnt = 0;
    wake_cnt = 0;
    t_reset();
    t_soft();
    t_periods();
    t_kick();
    t_window();
    t_sleep();
    finish_test();
  end
endmodule
